//--- rtl/mmbd_pkg.sv
// Constants shared by the memory map bank decoder
package mmbd_pkg;
  localparam logic [15:0] MMBD_NV_LO = 16'hFB00;
  localparam logic [15:0] MMBD_NV_HI = 16'hFCFF;
  localparam logic [15:0] MMBD_RAM_LO = 16'hFD00;
  localparam logic [15:0] MMBD_RAM_HI = 16'hFEFF;
  localparam logic [15:0] MMBD_PRW_LO = 16'hFF00;
  localparam logic [15:0] MMBD_XPRW_LO = 16'hFFD0;
  localparam logic [15:0] MMBD_XPRW_HI = 16'hFFDF;
  localparam int MMBD_NV_WORDS = 512;
  localparam int MMBD_NV_AW = 9;
  // AXI register byte addresses
  localparam logic [7:0] MMBD_A_MODE = 8'h00;
  localparam logic [7:0] MMBD_A_LATCH = 8'h04;
  localparam logic [7:0] MMBD_A_PMODE = 8'h08;
  localparam logic [7:0] MMBD_A_STAT = 8'h0C;
  localparam logic [7:0] MMBD_A_ASSIGN = 8'h10;
  // Mode register fields
  localparam int MMBD_M_EXT = 0;
  localparam int MMBD_M_MEG = 1;
  localparam logic [1:0] MMBD_RESP_OK = 2'h0;
  localparam logic [1:0] MMBD_RESP_SLV = 2'h2;
  localparam logic [3:0] MMBD_BANK0 = 4'h0;
  // Core access target
  typedef enum logic [2:0] {
    MMBD_T_NONE = 3'b000,
    MMBD_T_NV = 3'b001,
    MMBD_T_RAM = 3'b010,
    MMBD_T_PRW = 3'b011,
    MMBD_T_EXT = 3'b100,
    MMBD_T_BAD = 3'b101
  } mmbd_tgt_e;
  // Core access state
  typedef enum logic [1:0] {
    MMBD_S_IDLE = 2'b00,
    MMBD_S_EXT = 2'b01,
    MMBD_S_HUNG = 2'b10
  } mmbd_st_e;
endpackage

//--- rtl/mmbd_nv_mem.sv
// Nonvolatile array storage with registered read data
`timescale 1ns/100ps
module mmbd_nv_mem
  import mmbd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [MMBD_NV_AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem_q [0:MMBD_NV_WORDS-1];
  // Write or read one byte per enabled cycle
  always_ff @(posedge mclk_in) begin
    if (ce_in) begin
      if (we_in) begin
        mem_q[addr_in] <= wdata_in;
      end
      rdata_out <= mem_q[addr_in];
    end
  end
endmodule

//--- rtl/mmbd_top.sv
// Data memory map decoder with bank extension and AXI4-Lite control
// Operation
// RQ1: Decode FB00-FCFF to the on-chip nonvolatile array, read and write.
// RQ2: Software avoids word stores and nibble rotates on the nonvolatile region.
// RQ3: Map on-chip peripheral registers at FF00 through FFFF.
// RQ4: Unassigned peripheral addresses hang the core until reset.
// RQ5: Route FFD0-FFDF externally when ROM-less or expansion mode set.
// RQ6: External register window cycles use the ordinary external cycle.
// RQ7: Variant without external window keeps FFD0-FFDF internal.
// RQ8: External space reachable only when expansion mode enables it; nonzero-bank extended accesses in 1M-byte mode go external without it.
// RQ9: Addresses at 10000H and above need the 1M-byte mode.
// RQ10: In 1M-byte mode four port-six pins output address A16-A19.
// RQ11: Sixteen 64K banks chosen by latch or mode register nibble.
// RQ12: Bank bits driven only during extended-addressing instructions.
// RQ13: Ampersand prefix takes latch bank, otherwise mode nibble bank.
// RQ14: Sub-series keeps mode nibble at zero so plain accesses hit bank 0.
// RQ15: Software clears the mode nibble when expanded space is unused.
// RQ16: Bank nibble sits above 16-bit address forming a 20-bit address.
// RQ17: Internal RAM occupies FD00 through FEFF on this variant.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module mmbd_top
  import mmbd_pkg::*;
#(
  parameter bit HAS_NV = 1'b1,
  parameter bit HAS_XWIN = 1'b1,
  parameter bit ROMLESS = 1'b0
)(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Core access port
  input wire logic core_req_in,
  input wire logic core_we_in,
  input wire logic [15:0] core_addr_in,
  input wire logic [7:0] core_wdata_in,
  input wire logic core_ext_addr_in,
  input wire logic core_amp_in,
  output logic core_ack_out,
  output logic [7:0] core_rdata_out,
  output logic core_hung_out,
  output logic [2:0] core_tgt_out,
  output logic ram_sel_out,
  output logic prw_sel_out,
  input wire logic [7:0] int_rdata_in,
  // External bus
  output logic ext_req_out,
  output logic ext_we_out,
  output logic [19:0] ext_addr_out,
  output logic [7:0] ext_wdata_out,
  input wire logic ext_ack_in,
  input wire logic [7:0] ext_rdata_in,
  output logic [3:0] extended_address_pins_out,
  output logic extended_address_pins_en_n_out,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] memory_expansion_mode_reg_q, port_six_mode_bank_reg_q, awaddr_q;
  logic [7:0] rdata_out_q, ext_wdata_q;
  logic [3:0] port_six_latch_bank_reg_q, wstrb_q, xpins_q;
  logic [255:0] assigned_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q, ack_q;
  logic ext_req_q, ext_we_q, nv_rd_q, xpins_en_q;
  logic [19:0] ext_addr_q;
  logic [2:0] tgt_q;
  mmbd_st_e st_q;
  // Address decodes used more than once
  function automatic logic in_range(input logic [15:0] a, lo, hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction
  // Bitmap words: eight aligned offsets from the first bitmap address cover FF00-FFFF
  function automatic logic asg_hit(input logic [7:0] off);
    asg_hit = (off[7:5] == 3'h0) && (off[1:0] == 2'h0);
  endfunction
  // Region decode of the core address
  wire logic ext_mode = memory_expansion_mode_reg_q[MMBD_M_EXT] | ROMLESS;
  wire logic meg_mode = memory_expansion_mode_reg_q[MMBD_M_MEG];
  wire logic [3:0] mode_bank_nibble = port_six_mode_bank_reg_q[3:0];
  wire logic hit_nv = HAS_NV && in_range(core_addr_in, MMBD_NV_LO, MMBD_NV_HI); // RQ1
  wire logic hit_ram = HAS_NV && in_range(core_addr_in, MMBD_RAM_LO, MMBD_RAM_HI); // RQ17
  wire logic hit_prw = core_addr_in >= MMBD_PRW_LO; // RQ3
  wire logic hit_xwin = HAS_XWIN && ext_mode &&
    in_range(core_addr_in, MMBD_XPRW_LO, MMBD_XPRW_HI); // RQ5 RQ7
  wire logic prw_assigned = assigned_q[core_addr_in[7:0]];
  wire logic [3:0] sel_bank = core_amp_in ? port_six_latch_bank_reg_q
                                          : mode_bank_nibble; // RQ13 RQ11 RQ14
  wire logic use_bank = meg_mode && core_ext_addr_in; // RQ9 RQ12
  wire logic [3:0] phys_bank = use_bank ? sel_bank : MMBD_BANK0;
  wire logic low_ext = !hit_nv && !hit_ram && !hit_prw && ext_mode; // RQ8
  wire logic bank_ext = use_bank && (sel_bank != MMBD_BANK0); // RQ9
  wire mmbd_tgt_e tgt = bank_ext ? MMBD_T_EXT :
    hit_nv ? MMBD_T_NV :
    hit_ram ? MMBD_T_RAM :
    hit_xwin ? MMBD_T_EXT :
    (hit_prw && !prw_assigned) ? MMBD_T_BAD :
    hit_prw ? MMBD_T_PRW :
    low_ext ? MMBD_T_EXT : MMBD_T_NONE;
  wire logic go = clk_en_in && core_req_in && (st_q == MMBD_S_IDLE);
  wire logic nv_ce = clk_en_in && go && (tgt == MMBD_T_NV);
  wire logic [7:0] nv_rdata;
  mmbd_nv_mem u_nv (
    .mclk_in(mclk_in),
    .ce_in(nv_ce),
    .we_in(core_we_in),
    .addr_in(core_addr_in[MMBD_NV_AW-1:0]),
    .wdata_in(core_wdata_in),
    .rdata_out(nv_rdata)
  );
  // Core access sequencer
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_q <= MMBD_S_IDLE;
      ack_q <= 1'b0;
      rdata_out_q <= 8'h00;
      ext_req_q <= 1'b0;
      ext_we_q <= 1'b0;
      ext_addr_q <= 20'h00000;
      ext_wdata_q <= 8'h00;
      nv_rd_q <= 1'b0;
      xpins_q <= 4'h0;
      xpins_en_q <= 1'b0;
      tgt_q <= 3'h0;
    end else if (clk_en_in) begin
      ack_q <= 1'b0;
      nv_rd_q <= 1'b0;
      if (nv_rd_q) begin
        rdata_out_q <= nv_rdata;
      end
      case (st_q)
        MMBD_S_IDLE: begin
          if (core_req_in) begin
            tgt_q <= tgt;
            case (tgt)
              MMBD_T_EXT: begin
                st_q <= MMBD_S_EXT; // RQ6
                ext_req_q <= 1'b1;
                ext_we_q <= core_we_in;
                ext_addr_q <= {phys_bank, core_addr_in}; // RQ16
                ext_wdata_q <= core_wdata_in;
                xpins_q <= phys_bank; // RQ10
                xpins_en_q <= use_bank; // RQ12
              end
              MMBD_T_BAD: st_q <= MMBD_S_HUNG; // RQ4
              MMBD_T_NV: begin
                ack_q <= 1'b1;
                nv_rd_q <= !core_we_in;
              end
              default: begin
                ack_q <= 1'b1;
                rdata_out_q <= int_rdata_in;
              end
            endcase
          end
        end
        MMBD_S_EXT: begin
          if (ext_ack_in) begin
            st_q <= MMBD_S_IDLE;
            ext_req_q <= 1'b0;
            xpins_en_q <= 1'b0;
            ack_q <= 1'b1;
            rdata_out_q <= ext_rdata_in;
          end
        end
        MMBD_S_HUNG: st_q <= MMBD_S_HUNG; // RQ4
        default: st_q <= MMBD_S_IDLE;
      endcase
    end
  end
  // AXI write channel capture and register update
  wire logic aw_take = s_axi_awvalid && !aw_have_q && !bvalid_q;
  wire logic w_take = s_axi_wvalid && !w_have_q && !bvalid_q;
  wire logic wr_fire = aw_have_q && w_have_q && !bvalid_q;
  wire logic [7:0] aw_off = awaddr_q - MMBD_A_ASSIGN;
  wire logic wr_ok = (awaddr_q == MMBD_A_MODE) || (awaddr_q == MMBD_A_LATCH) ||
    (awaddr_q == MMBD_A_PMODE) || asg_hit(aw_off);
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= MMBD_RESP_OK;
      memory_expansion_mode_reg_q <= 8'h00;
      port_six_latch_bank_reg_q <= 4'h0;
      port_six_mode_bank_reg_q <= 8'h00;
      assigned_q <= '0;
    end else if (clk_en_in) begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? MMBD_RESP_OK : MMBD_RESP_SLV;
        if (wstrb_q[0] && awaddr_q == MMBD_A_MODE) begin
          memory_expansion_mode_reg_q <= wdata_q[7:0];
        end
        if (wstrb_q[0] && awaddr_q == MMBD_A_LATCH) begin
          port_six_latch_bank_reg_q <= wdata_q[3:0];
        end
        if (wstrb_q[0] && awaddr_q == MMBD_A_PMODE) begin
          port_six_mode_bank_reg_q <= wdata_q[7:0];
        end
        if (asg_hit(aw_off)) begin
          assigned_q[aw_off[4:2]*32 +: 32] <= wdata_q;
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  // AXI read decode
  wire logic [7:0] ar_off = s_axi_araddr - MMBD_A_ASSIGN;
  wire logic [31:0] rd_mux =
    (s_axi_araddr == MMBD_A_MODE) ? {24'h000000, memory_expansion_mode_reg_q} :
    (s_axi_araddr == MMBD_A_LATCH) ? {28'h0000000, port_six_latch_bank_reg_q} :
    (s_axi_araddr == MMBD_A_PMODE) ? {24'h000000, port_six_mode_bank_reg_q} :
    (s_axi_araddr == MMBD_A_STAT) ? {27'h0000000, core_hung_out, st_q, tgt_q[1:0]} :
    asg_hit(ar_off) ? assigned_q[ar_off[4:2]*32 +: 32] :
    32'h00000000;
  wire logic rd_ok = (s_axi_araddr == MMBD_A_MODE) || (s_axi_araddr == MMBD_A_LATCH) ||
    (s_axi_araddr == MMBD_A_PMODE) || (s_axi_araddr == MMBD_A_STAT) || asg_hit(ar_off);
  wire logic ar_take = s_axi_arvalid && !rvalid_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rresp_q <= MMBD_RESP_OK;
      rdata_q <= 32'h00000000;
    end else if (clk_en_in) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? MMBD_RESP_OK : MMBD_RESP_SLV;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  // Output drive
  assign s_axi_awready = clk_en_in && !aw_have_q && !bvalid_q;
  assign s_axi_wready = clk_en_in && !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = clk_en_in && !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign core_ack_out = ack_q;
  assign core_rdata_out = rdata_out_q;
  assign core_hung_out = (st_q == MMBD_S_HUNG);
  assign core_tgt_out = tgt;
  assign ram_sel_out = go && (tgt == MMBD_T_RAM);
  assign prw_sel_out = go && (tgt == MMBD_T_PRW);
  assign ext_req_out = ext_req_q;
  assign ext_we_out = ext_we_q;
  assign ext_addr_out = ext_addr_q;
  assign ext_wdata_out = ext_wdata_q;
  assign extended_address_pins_out = xpins_q;
  assign extended_address_pins_en_n_out = !xpins_en_q; // RQ12
  // Checks
  property p_hang;
    @(posedge mclk_in) disable iff (rst_in) (go && tgt == MMBD_T_BAD) |=> core_hung_out [*3];
  endproperty
  a_hang: assert property (p_hang) else $error("bad access did not hang"); // RQ4
  property p_ext_addr;
    @(posedge mclk_in) disable iff (rst_in)
      (go && tgt == MMBD_T_EXT) |=> ext_req_out && ext_addr_out[15:0] == $past(core_addr_in);
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("external address wrong"); // RQ16
  property p_bank_sel;
    @(posedge mclk_in) disable iff (rst_in)
      (go && tgt == MMBD_T_EXT && use_bank && core_amp_in) |=>
        ext_addr_out[19:16] == $past(port_six_latch_bank_reg_q);
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("latch bank not used"); // RQ13
  property p_nobank;
    @(posedge mclk_in) disable iff (rst_in)
      (go && !meg_mode) |=> ext_addr_out[19:16] == MMBD_BANK0 || !ext_req_out;
  endproperty
  a_nobank: assert property (p_nobank) else $error("bank without 1M mode"); // RQ9
  property p_pins;
    @(posedge mclk_in) disable iff (rst_in)
      !extended_address_pins_en_n_out |-> ext_req_out && extended_address_pins_out ==
        ext_addr_out[19:16];
  endproperty
  a_pins: assert property (p_pins) else $error("pins off bus cycle"); // RQ10 RQ12
  property p_nv;
    @(posedge mclk_in) disable iff (rst_in)
      (go && in_range(core_addr_in, MMBD_NV_LO, MMBD_NV_HI) && !use_bank) |->
        (tgt == MMBD_T_NV) == HAS_NV;
  endproperty
  a_nv: assert property (p_nv) else $error("nonvolatile decode wrong"); // RQ1
  property p_xwin;
    @(posedge mclk_in) disable iff (rst_in)
      (go && !use_bank && in_range(core_addr_in, MMBD_XPRW_LO, MMBD_XPRW_HI)) |->
        (tgt == MMBD_T_EXT) == (HAS_XWIN && ext_mode);
  endproperty
  a_xwin: assert property (p_xwin) else $error("external window decode wrong"); // RQ5 RQ7
  property p_ext_gate;
    @(posedge mclk_in) disable iff (rst_in) (go && tgt == MMBD_T_EXT) |-> ext_mode || use_bank;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("external without mode"); // RQ8
  property p_ext_done;
    @(posedge mclk_in) disable iff (rst_in)
      (st_q == MMBD_S_EXT && ext_ack_in && clk_en_in) |=> core_ack_out && !ext_req_out;
  endproperty
  a_ext_done: assert property (p_ext_done) else $error("external cycle end wrong"); // RQ6
endmodule

//--- test/mmbd_ext_model.sv
// External bus partner that answers each cycle after a set delay
`timescale 1ns/100ps
module mmbd_ext_model (
  input wire logic mclk_in,
  input wire logic [3:0] delay_in,
  input wire logic ext_req_in,
  input wire logic [19:0] ext_addr_in,
  output logic ext_ack_out,
  output logic [7:0] ext_rdata_out
);
  logic [3:0] wait_q = 4'h0;
  logic gap_q = 1'h0;
  initial begin
    ext_ack_out = 1'h0;
    ext_rdata_out = 8'h00;
  end
  // One-cycle acknowledge; read data is junk that toggles outside it
  always @(posedge mclk_in) begin
    ext_rdata_out <= ~ext_rdata_out;
    if (ext_ack_out) begin
      ext_ack_out <= 1'h0;
      gap_q <= 1'h1;
    end else if (gap_q) begin
      gap_q <= 1'h0;
    end else if (ext_req_in && wait_q == delay_in) begin
      ext_ack_out <= 1'h1;
      ext_rdata_out <= ext_addr_in[7:0] ^ {ext_addr_in[19:16], ext_addr_in[11:8]};
      wait_q <= 4'h0;
    end else if (ext_req_in) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

//--- test/test_memory_map_bank_decoder.sv
// Self-checking bench for the memory map bank decoder
`timescale 1ns/100ps
module test_memory_map_bank_decoder;
  import mmbd_pkg::*;
  logic mclk_in = 1'h0, rst_in = 1'h1, clk_en_in = 1'h1;
  logic core_req_in = 1'h0, core_we_in = 1'h0, core_ext_addr_in = 1'h0, core_amp_in = 1'h0;
  logic [15:0] core_addr_in = 16'h0000;
  logic [7:0] core_wdata_in = 8'h00, int_rdata_in = 8'h3C, ext_rdata_in, core_rdata_out;
  logic core_ack_out, core_hung_out, ram_sel_out, prw_sel_out, ext_req_out, ext_we_out;
  logic ext_ack_in, extended_address_pins_en_n_out;
  logic [7:0] ext_wdata_out, q8;
  logic [2:0] core_tgt_out;
  logic [19:0] ext_addr_out;
  logic [3:0] extended_address_pins_out, delay = 4'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] c_tgt;
  logic c_ack, c_sel, c_x, c_xwe, c_pen;
  logic [19:0] c_xa;
  logic [7:0] c_xwd, c_rd, c_nv;
  logic [3:0] c_pins;
  logic [7:0] regs [3] = '{MMBD_A_MODE, MMBD_A_LATCH, MMBD_A_PMODE};
  int failures = 0, total_checks = 0;

  always #4 mclk_in = ~mclk_in;

  mmbd_top dut (
    .mclk_in, .rst_in, .clk_en_in, .core_req_in, .core_we_in, .core_addr_in, .core_wdata_in,
    .core_ext_addr_in, .core_amp_in, .core_ack_out, .core_rdata_out, .core_hung_out,
    .core_tgt_out, .ram_sel_out, .prw_sel_out, .int_rdata_in, .ext_req_out, .ext_we_out,
    .ext_addr_out, .ext_wdata_out, .ext_ack_in, .ext_rdata_in, .extended_address_pins_out,
    .extended_address_pins_en_n_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  mmbd_ext_model partner (.mclk_in, .delay_in(delay), .ext_req_in(ext_req_out),
    .ext_addr_in(ext_addr_out), .ext_ack_out(ext_ack_in), .ext_rdata_out(ext_rdata_in));

  // Verdict and end of run
  task end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task reset_dut();
    rst_in <= 1'h1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'h0;
    @(posedge mclk_in);
  endtask

  // AXI4-Lite single transfer; ready and valid are sampled mid-cycle, acted on at the edge
  task axi(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic aw, w, done;
    done = 1'h0;
    if (we) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    while (!done) begin
      @(negedge mclk_in);
      aw = we ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
      w = s_axi_wvalid & s_axi_wready;
      done = we ? s_axi_bvalid : s_axi_rvalid;
      r = we ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge mclk_in);
      if (aw && we) s_axi_awvalid <= 1'h0;
      if (aw && !we) s_axi_arvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    // One idle edge keeps the next call's raise apart from this release
    @(posedge mclk_in);
  endtask

  // One core access: request taken at one edge, then wait for the acknowledge
  task core(input logic [15:0] a, input logic we, input logic [7:0] wd, input logic xa,
            input logic amp);
    int n;
    core_addr_in <= a;
    core_we_in <= we;
    core_wdata_in <= wd;
    core_ext_addr_in <= xa;
    core_amp_in <= amp;
    core_req_in <= 1'h1;
    c_ack = 1'h0;
    c_x = 1'h0;
    n = 0;
    @(negedge mclk_in);
    c_tgt = core_tgt_out;
    c_sel = ram_sel_out | prw_sel_out;
    @(posedge mclk_in);
    core_req_in <= 1'h0;
    while (!c_ack && n < 40) begin
      @(negedge mclk_in);
      if (ext_req_out && !c_x) begin
        c_x = 1'h1;
        c_xa = ext_addr_out;
        c_xwe = ext_we_out;
        c_xwd = ext_wdata_out;
        c_pins = extended_address_pins_out;
        c_pen = extended_address_pins_en_n_out;
      end
      c_ack = core_ack_out;
      c_rd = core_rdata_out;
      n++;
    end
    @(negedge mclk_in);
    c_nv = core_rdata_out;
    @(posedge mclk_in);
  endtask

  // External read seen on the bus with the partner's data returned
  task ext_rd(input logic [19:0] ea, input logic en);
    chk(c_x, 1'h1);
    chk(c_xa, ea);
    chk(c_pen, en);
    if (!en) chk(c_pins, ea[19:16]);
    q8 = ea[7:0] ^ {ea[19:16], ea[11:8]};
    chk(c_rd, q8);
  endtask

  // Main sequence
  initial begin
    reset_dut();
    foreach (regs[i]) begin
      axi(1'h0, regs[i], 32'h0);
      chk(q, 32'h0);
    end
    axi(1'h0, 8'h40, 32'h0);
    chk(r, MMBD_RESP_SLV);
    axi(1'h1, 8'h40, 32'h1);
    chk(r, MMBD_RESP_SLV);
    core(16'hFB00, 1'h1, 8'h5A, 1'h0, 1'h0);
    chk(c_tgt, MMBD_T_NV);
    core(16'hFCFF, 1'h1, 8'hC3, 1'h0, 1'h0);
    core(16'hFB00, 1'h0, 8'h00, 1'h0, 1'h0);
    chk(c_nv, 8'h5A);
    core(16'hFCFF, 1'h0, 8'h00, 1'h0, 1'h0);
    chk(c_nv, 8'hC3);
    core(16'hFD00, 1'h0, 8'h00, 1'h0, 1'h0);
    chk({c_tgt, c_sel, c_ack}, {MMBD_T_RAM, 2'h3});
    chk(c_rd, 8'h3C);
    core(16'hFEFF, 1'h0, 8'h00, 1'h0, 1'h0);
    chk(c_tgt, MMBD_T_RAM);
    core(16'h1234, 1'h0, 8'h00, 1'h0, 1'h0);
    chk(c_x, 1'h0);
    axi(1'h1, MMBD_A_ASSIGN, 32'h20);
    core(16'hFF05, 1'h0, 8'h00, 1'h0, 1'h0);
    chk({c_tgt, c_sel, c_ack, c_x}, {MMBD_T_PRW, 3'h6});
    core(16'hFF25, 1'h0, 8'h00, 1'h0, 1'h0);
    chk({c_ack, core_hung_out}, 2'h1);
    core(16'hFB00, 1'h0, 8'h00, 1'h0, 1'h0);
    chk({c_ack, core_hung_out}, 2'h1);
    reset_dut();
    chk(core_hung_out, 1'h0);
    axi(1'h1, MMBD_A_MODE, 32'h1);
    core(16'h1234, 1'h0, 8'h00, 1'h0, 1'h0);
    chk(c_tgt, MMBD_T_EXT);
    ext_rd(20'h01234, 1'h1);
    core(16'hFFD0, 1'h1, 8'h77, 1'h0, 1'h0);
    chk({c_x, c_xa, c_xwe, c_xwd}, {1'h1, 20'h0FFD0, 1'h1, 8'h77});
    delay <= 4'h6;
    core(16'hFFDF, 1'h0, 8'h00, 1'h0, 1'h0);
    ext_rd(20'h0FFDF, 1'h1);
    axi(1'h1, MMBD_A_LATCH, 32'h5);
    axi(1'h1, MMBD_A_PMODE, 32'h1);
    core(16'h2000, 1'h0, 8'h00, 1'h1, 1'h1);
    ext_rd(20'h02000, 1'h1);
    axi(1'h1, MMBD_A_MODE, 32'h3);
    delay <= 4'h0;
    for (int b = 1; b < 16; b++) begin
      axi(1'h1, MMBD_A_LATCH, 32'(b));
      core(16'hABCD, 1'h0, 8'h00, 1'h1, 1'h1);
      ext_rd({4'(b), 16'hABCD}, 1'h0);
    end
    core(16'h2000, 1'h0, 8'h00, 1'h1, 1'h0);
    ext_rd(20'h12000, 1'h0);
    core(16'h2000, 1'h0, 8'h00, 1'h0, 1'h1);
    ext_rd(20'h02000, 1'h1);
    core(16'h3000, 1'h1, 8'h99, 1'h1, 1'h0);
    chk({c_xa, c_xwe, c_xwd}, {20'h13000, 1'h1, 8'h99});
    axi(1'h1, MMBD_A_PMODE, 32'h0);
    reset_dut();
    axi(1'h0, MMBD_A_MODE, 32'h0);
    chk(q, 32'h0);
    end_of_test();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk_in);
    failures++;
    end_of_test();
  end
endmodule
